/* core/timer_action_consts.svh */
// register indices, field positions and reset values for the timer action block
// assumes byte address = 4 * index, data in the low byte of a 32-bit word
`ifndef TIMER_ACTION_CONSTS_SVH
`define TIMER_ACTION_CONSTS_SVH

`define IDX_SELECT       6'h00
`define IDX_C7_MASK      6'h02
`define IDX_C7_DATA      6'h03
`define IDX_COUNT_HI     6'h04
`define IDX_COUNT_LO     6'h05
`define IDX_SYS_ONE      6'h06
`define IDX_TOGGLE       6'h07
`define IDX_ACTION_HI    6'h08
`define IDX_ACTION_LO    6'h09
`define IDX_EDGE_HI      6'h0A
`define IDX_EDGE_LO      6'h0B
`define IDX_SYS_TWO      6'h0D
`define IDX_CH_FLAG      6'h0E
`define IDX_OVF_FLAG     6'h0F
`define IDX_CH_FIRST     6'h10
`define IDX_CH_LAST      6'h1F
`define IDX_ACC_FLAG     6'h21
`define IDX_ACC_HI       6'h22
`define IDX_ACC_LO       6'h23
`define IDX_DISCONNECT   6'h2C
`define IDX_PRECISION    6'h2F

`define BIT_ENABLE       7
`define BIT_FAST_CLEAR   4
`define BIT_PRECISION    3
`define BIT_TOF          7
`define BIT_ACC_OVF      1
`define BIT_ACC_INPUT    0
`define PR_LSB           0
`define PR_MSB           2

`define RESET_BYTE       8'h00
`define RESET_WORD       16'h0000
`define COUNT_MAX        16'hFFFF
`define COUNT_ONE        16'h0001
`define PRE_ONE          8'h01

`endif

/* core/timer_action_pkg.sv */
// types shared by the timer action block
// assumes timer_action_consts.svh for all numbers
package timer_action_pkg;

    typedef struct packed {
        logic [7:0]  paddr;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef enum logic [1:0] {
        act_none   = 2'h0,
        act_toggle = 2'h1,
        act_clear  = 2'h2,
        act_set    = 2'h3
    } pin_action_t;

    typedef enum logic [1:0] {
        edge_off     = 2'h0,
        edge_rising  = 2'h1,
        edge_falling = 2'h2,
        edge_any     = 2'h3
    } edge_mode_t;

endpackage

/* core/timer_channel_action_control.sv */
// eight-channel 16-bit timer: compare pin actions, capture edges, fast flag clear
// assumes an APB master on pclk; channel pins come from outside and are synchronised
// Notes on behaviour
// R01: fast clear off: flags clear only by writing ones to flag registers.
// R02: fast clear on: capture read or compare write clears that channel flag.
// R03: fast clear on: any counter byte access clears the overflow flag.
// R04: fast clear on: accumulator count access clears both accumulator flags.
// R05: precision select picks legacy three-bit prescale or full precision prescaler.
// R06: precision select takes only the first write after reset.
// R07: toggle bit inverts compare pin on counter overflow, compare mode only.
// R08: overflow toggle beats own compare action, yields to channel 7 override.
// R09: compare pair: 00 none, 01 toggle, 10 clear, 11 set.
// R10: any nonzero compare pair makes the pin an output of compare logic.
// R11: software clears mask and disconnect bits to let the pair drive; the code lets the mask block the pair on channel 7 only.
// R12: software sets channels 7,0 to compare, pairs 00, mask 7 clear.
// R13: channel 7 follows its pair unless masked, then takes its data bit.
// R14: masked channel with equal values takes channel 7 data alone.
// R15: software puts channel 7 and affected channel in compare mode.
// R16: capture pair: 00 off, 01 rising, 10 falling, 11 both edges.
// R17: channel 7 match or toggled overflow overrides masked channel compares.
// R18: data transfer needs compare mode and disconnect bit clear.
// R19: flag set event wins over a clearing access in the same cycle.
// R20: overflow toggle happens in the wrap cycle together with the flag.
//
// Added by the designer: register access over APB.
`timescale 1ns/10ps
`include "timer_action_consts.svh"

module timer_channel_action_control (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // pulse accumulator side
    input  wire logic [15:0] acc_count,
    input  wire logic        acc_overflow_event,
    input  wire logic        acc_input_event,
    // channel pins
    input  wire logic [7:0]  chan_pin_in,
    output logic [7:0]       chan_pin_out,
    output logic [7:0]       chan_pin_oe_n
);

    timer_action_pkg::apb_req_t req;
    logic [7:0]  select_reg, c7_mask, c7_data, sys_one, toggle_en, sys_two, disconnect;
    logic [7:0]  precision_pre, ch_flag, acc_flag;
    logic [15:0] action_ctl, edge_ctl;
    logic        overflow_flag, precision_locked;
    logic [15:0] main_counter, next_counter;
    logic [7:0]  pre_count;
    logic [15:0] chan_value [8];
    logic [7:0]  pin_meta, pin_sync, pin_prev;
    logic [7:0]  match, captured, rd_byte;
    logic        access, wr_en, rd_en, tick, overflow, ch7_event, mapped;
    logic [5:0]  idx;

    assign req    = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign idx    = req.paddr[7:2];
    assign access = psel && penable;
    assign wr_en  = access && req.pwrite;
    assign rd_en  = access && !req.pwrite;
    assign pready = 1'b1;

    // prescale divide factor as a terminal count minus one
    function automatic logic [7:0] prescale_last(input logic precise, input logic [7:0] pre,
                                                  input logic [2:0] sel);
        logic [7:0] legacy;
        legacy = (`PRE_ONE << sel) - `PRE_ONE;
        return precise ? pre : legacy;
    endfunction

    function automatic logic hit(input logic [5:0] want);
        return idx == want;
    endfunction

    function automatic logic in_channels();
        return idx >= `IDX_CH_FIRST && idx <= `IDX_CH_LAST;
    endfunction

    // counter and prescaler
    assign tick = sys_one[`BIT_ENABLE] &&
                  pre_count == prescale_last(sys_one[`BIT_PRECISION], precision_pre,
                                             sys_two[`PR_MSB:`PR_LSB]); // [R05]
    assign next_counter = main_counter + `COUNT_ONE;
    assign overflow     = tick && main_counter == `COUNT_MAX;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_count    <= `RESET_BYTE;
            main_counter <= `RESET_WORD;
        end else if (sys_one[`BIT_ENABLE]) begin
            pre_count <= tick ? `RESET_BYTE : pre_count + `PRE_ONE;
            if (tick) begin
                main_counter <= next_counter;
            end
        end
    end

    // compare match fires when the counter steps onto the channel value
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            match[i] = tick && select_reg[i] && next_counter == chan_value[i];
        end
    end
    assign ch7_event = match[7] || (overflow && toggle_en[7]); // [R17]

    // pin input synchroniser and edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= `RESET_BYTE;
            pin_sync <= `RESET_BYTE;
            pin_prev <= `RESET_BYTE;
        end else begin
            pin_meta <= chan_pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    always_comb begin
        for (int i = 0; i < 8; i++) begin
            case (timer_action_pkg::edge_mode_t'(edge_ctl[2*i +: 2])) // [R16]
                timer_action_pkg::edge_rising:  captured[i] = pin_sync[i] && !pin_prev[i];
                timer_action_pkg::edge_falling: captured[i] = !pin_sync[i] && pin_prev[i];
                timer_action_pkg::edge_any:     captured[i] = pin_sync[i] != pin_prev[i];
                default:                        captured[i] = 1'b0;
            endcase
            captured[i] = captured[i] && !select_reg[i];
        end
    end

    // channel value registers: software writes bytes, capture latches the counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 8; i++) begin
                chan_value[i] <= `RESET_WORD;
            end
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (captured[i]) begin
                    chan_value[i] <= main_counter;
                end else if (wr_en && in_channels() && idx[3:1] == 3'(i)) begin
                    if (idx[0]) begin
                        chan_value[i][7:0] <= req.pwdata[7:0];
                    end else begin
                        chan_value[i][15:8] <= req.pwdata[7:0];
                    end
                end
            end
        end
    end

    // plain control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            select_reg    <= `RESET_BYTE;
            c7_mask       <= `RESET_BYTE;
            c7_data       <= `RESET_BYTE;
            toggle_en     <= `RESET_BYTE;
            action_ctl    <= `RESET_WORD;
            edge_ctl      <= `RESET_WORD;
            sys_two       <= `RESET_BYTE;
            disconnect    <= `RESET_BYTE;
            precision_pre <= `RESET_BYTE;
        end else if (wr_en) begin
            case (idx)
                `IDX_SELECT:     select_reg        <= req.pwdata[7:0];
                `IDX_C7_MASK:    c7_mask           <= req.pwdata[7:0];
                `IDX_C7_DATA:    c7_data           <= req.pwdata[7:0];
                `IDX_TOGGLE:     toggle_en         <= req.pwdata[7:0];
                `IDX_ACTION_HI:  action_ctl[15:8]  <= req.pwdata[7:0];
                `IDX_ACTION_LO:  action_ctl[7:0]   <= req.pwdata[7:0];
                `IDX_EDGE_HI:    edge_ctl[15:8]    <= req.pwdata[7:0];
                `IDX_EDGE_LO:    edge_ctl[7:0]     <= req.pwdata[7:0];
                `IDX_SYS_TWO:    sys_two           <= req.pwdata[7:0];
                `IDX_DISCONNECT: disconnect        <= req.pwdata[7:0];
                `IDX_PRECISION:  precision_pre     <= req.pwdata[7:0];
                default: ;
            endcase
        end
    end

    // system control one: precision select is write-once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_one          <= `RESET_BYTE;
            precision_locked <= 1'b0;
        end else if (wr_en && hit(`IDX_SYS_ONE)) begin
            precision_locked <= 1'b1;
            sys_one          <= {req.pwdata[7:4],
                                 precision_locked ? sys_one[`BIT_PRECISION]
                                                  : req.pwdata[`BIT_PRECISION],
                                 req.pwdata[2:0]}; // [R06]
        end
    end

    // flags: set beats every kind of clear in the same cycle
    logic [7:0] ch_clear;
    logic       tof_clear, acc_clear, fast;
    assign fast = sys_one[`BIT_FAST_CLEAR];
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ch_clear[i] = wr_en && hit(`IDX_CH_FLAG) && req.pwdata[i]; // [R01]
            if (fast && access && in_channels() && idx[3:1] == 3'(i)) begin
                ch_clear[i] = ch_clear[i] ||
                              (rd_en && !select_reg[i]) || (wr_en && select_reg[i]); // [R02]
            end
        end
    end
    assign tof_clear = (wr_en && hit(`IDX_OVF_FLAG) && req.pwdata[`BIT_TOF]) ||
                       (fast && access && (hit(`IDX_COUNT_HI) || hit(`IDX_COUNT_LO))); // [R03]
    assign acc_clear = fast && access && (hit(`IDX_ACC_HI) || hit(`IDX_ACC_LO)); // [R04]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ch_flag       <= `RESET_BYTE;
            overflow_flag <= 1'b0;
            acc_flag      <= `RESET_BYTE;
        end else begin
            ch_flag       <= (ch_flag & ~ch_clear) | match | captured; // [R19]
            overflow_flag <= (overflow_flag && !tof_clear) || overflow; // [R19]
            acc_flag[`BIT_ACC_OVF] <= (acc_flag[`BIT_ACC_OVF] && !acc_clear &&
                                       !(wr_en && hit(`IDX_ACC_FLAG) &&
                                         req.pwdata[`BIT_ACC_OVF])) ||
                                      acc_overflow_event; // [R04] [R19]
            acc_flag[`BIT_ACC_INPUT] <= (acc_flag[`BIT_ACC_INPUT] && !acc_clear &&
                                         !(wr_en && hit(`IDX_ACC_FLAG) &&
                                           req.pwdata[`BIT_ACC_INPUT])) ||
                                        acc_input_event; // [R04] [R19]
        end
    end

    // pin actions, highest priority last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chan_pin_out <= `RESET_BYTE;
        end else begin
            for (int i = 0; i < 8; i++) begin
                if (select_reg[i] && !disconnect[i]) begin
                    if (match[i] && !c7_mask[i] || match[i] && i != 7) begin
                        case (timer_action_pkg::pin_action_t'(action_ctl[2*i +: 2])) // [R09]
                            timer_action_pkg::act_toggle: chan_pin_out[i] <= !chan_pin_out[i];
                            timer_action_pkg::act_clear:  chan_pin_out[i] <= 1'b0;
                            timer_action_pkg::act_set:    chan_pin_out[i] <= 1'b1;
                            default: ;
                        endcase
                    end
                    if (overflow && toggle_en[i]) begin
                        chan_pin_out[i] <= !chan_pin_out[i]; // [R07] [R08] [R20]
                    end
                    if (ch7_event && c7_mask[i] && select_reg[7]) begin
                        chan_pin_out[i] <= c7_data[i]; // [R13] [R14] [R17] [R18]
                    end
                end
            end
        end
    end

    // output enable low while compare logic owns the pin
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            chan_pin_oe_n[i] = !(select_reg[i] && !disconnect[i] &&
                                 (action_ctl[2*i +: 2] != 2'h0 || c7_mask[i])); // [R10]
        end
    end

    // read mux, captured in the setup phase so data comes from flip-flops
    always_comb begin
        mapped  = 1'b1;
        rd_byte = `RESET_BYTE;
        case (idx)
            `IDX_SELECT:     rd_byte = select_reg;
            `IDX_C7_MASK:    rd_byte = c7_mask;
            `IDX_C7_DATA:    rd_byte = c7_data;
            `IDX_COUNT_HI:   rd_byte = main_counter[15:8];
            `IDX_COUNT_LO:   rd_byte = main_counter[7:0];
            `IDX_SYS_ONE:    rd_byte = sys_one;
            `IDX_TOGGLE:     rd_byte = toggle_en;
            `IDX_ACTION_HI:  rd_byte = action_ctl[15:8];
            `IDX_ACTION_LO:  rd_byte = action_ctl[7:0];
            `IDX_EDGE_HI:    rd_byte = edge_ctl[15:8];
            `IDX_EDGE_LO:    rd_byte = edge_ctl[7:0];
            `IDX_SYS_TWO:    rd_byte = sys_two;
            `IDX_CH_FLAG:    rd_byte = ch_flag;
            `IDX_OVF_FLAG:   rd_byte = {overflow_flag, 7'h00};
            `IDX_ACC_FLAG:   rd_byte = acc_flag;
            `IDX_ACC_HI:     rd_byte = acc_count[15:8];
            `IDX_ACC_LO:     rd_byte = acc_count[7:0];
            `IDX_DISCONNECT: rd_byte = disconnect;
            `IDX_PRECISION:  rd_byte = precision_pre;
            default: begin
                if (in_channels()) begin
                    rd_byte = idx[0] ? chan_value[idx[3:1]][7:0] : chan_value[idx[3:1]][15:8];
                end else begin
                    mapped = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            prdata  <= {24'h000000, rd_byte};
            pslverr <= !mapped;
        end
    end

endmodule // timer_channel_action_control

/* verification/timer_action_chk.sv */
// checker for the timer action block, watching its top-level ports only
// assumes apb writes land at the access edge and pready stays high
`timescale 1ns/10ps
module timer_action_chk (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // pins
    input wire logic [7:0]  chan_pin_out,
    input wire logic [7:0]  chan_pin_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic [7:0]  sel, msk, dat, overflow_toggle_bit, dis, quiet, led, drv;
    logic [15:0] act;
    logic        sys_seen, prec;
    wire         acc = psel & penable & pready;
    wire [5:0]   idx = paddr[7:2];

    // shadow of the control registers, built from the bus alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {sel, msk, dat, overflow_toggle_bit, dis, act, sys_seen, prec} <= '0;
        end else if (acc && pwrite) begin
            case (idx)
                6'h00: sel <= pwdata[7:0];
                6'h02: msk <= pwdata[7:0];
                6'h03: dat <= pwdata[7:0];
                6'h07: overflow_toggle_bit <= pwdata[7:0];
                6'h08: act[15:8] <= pwdata[7:0];
                6'h09: act[7:0] <= pwdata[7:0];
                6'h2C: dis <= pwdata[7:0];
                6'h06: begin
                    sys_seen <= 1'b1;
                    if (!sys_seen)
                        prec <= pwdata[3];
                end
                default: ;
            endcase
        end
    end

    // quiet: nothing may move the pin; led: only channel 7 data may move it
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            drv[i] = sel[i] & ~dis[i] & ((act[2*i +: 2] != 2'h0) | msk[i]);
            quiet[i] = sel[i] & ~msk[i] & (act[2*i +: 2] == 2'h0) & ~overflow_toggle_bit[i];
            led[i] = sel[i] & ~dis[i] & msk[i]
                     & ((i == 7) | ((act[2*i +: 2] == 2'h0) & ~overflow_toggle_bit[i]));
        end
    end

    AST_OE_DRIVE: assert property (chan_pin_oe_n == ~drv)
        else $error("pin enables do not follow compare setup");
    AST_OE_HOLD: assert property (!$past(acc && pwrite) |-> $stable(chan_pin_oe_n))
        else $error("pin enables moved without a write");
    AST_PIN_QUIET: assert property ((chan_pin_out & quiet) == ($past(chan_pin_out) & quiet))
        else $error("pin moved with no action selected");
    AST_MASK_DATA: assert property ((($past(chan_pin_out) ^ chan_pin_out) & led
                                    & (chan_pin_out ^ dat)) == 8'h00)
        else $error("masked pin took a value other than channel 7 data");
    AST_PREC_LOCK: assert property (acc && !pwrite && idx == 6'h06 |-> prdata[3] == prec)
        else $error("precision select changed after its first write");
    AST_READY: assert property (pready)
        else $error("ready dropped");
    AST_UPPER_ZERO: assert property (acc |-> prdata[31:8] == 24'h000000)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (acc && idx > 6'h2F |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    cover property (acc && pwrite && idx[5:4] == 2'h1);
    cover property ($changed(chan_pin_out[7]));
    cover property (acc && pslverr);
endmodule // timer_action_chk

bind timer_channel_action_control timer_action_chk u_chk (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .chan_pin_out, .chan_pin_oe_n
);

/* verification/timer_pin_partner.sv */
// external drivers on the eight timer channel pins
// assumes oe_n low means the block drives the pin
`timescale 1ns/10ps
module timer_pin_partner (
    // clock
    input wire logic       pclk,
    // block side
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe_n,
    // resolved level
    output logic [7:0]     pin_level
);
    logic [7:0] ext = 8'h00;

    // a pin the block drives shows the block's level, others ours
    assign pin_level = (pin_oe_n & ext) | (~pin_oe_n & pin_out);

    // edges launched just after a clock edge keep capture timing fixed
    task automatic drive(input logic [7:0] v);
        @(posedge pclk);
        ext <= v;
    endtask
endmodule // timer_pin_partner

/* verification/test_timer_channel_action_control.sv */
// self-checking bench for the timer action block
// assumes zero-wait apb, byte address = 4 * index, divide-by-1 precision prescale
`timescale 1ns/10ps
`define CHK(got, exp) \
    begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end

module test_timer_channel_action_control;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000;
    logic        pready, pslverr, err;
    logic [31:0] prdata;
    logic [15:0] acc_count = 16'hA55A;
    logic        acc_ovf = 1'b0;
    logic        acc_in = 1'b0;
    logic [7:0]  pin_in, pin_out, oe_n, rd;
    int          checks = 0;
    int          n_mismatch = 0;
    // {index, data}: legacy prescale 128 so a wrong prescale source misses the matches
    logic [13:0] cfg [15] = '{{6'h00, 8'hCF}, {6'h2C, 8'h00}, {6'h09, 8'h27}, {6'h08, 8'hA0},
        {6'h02, 8'hC0}, {6'h03, 8'hC0}, {6'h0A, 8'h09}, {6'h07, 8'h12}, {6'h11, 8'h10},
        {6'h13, 8'h10}, {6'h15, 8'h10}, {6'h17, 8'h08}, {6'h1D, 8'h20}, {6'h1F, 8'h20},
        {6'h0D, 8'h07}};

    always #50 pclk = ~pclk;

    timer_channel_action_control u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .acc_count, .acc_overflow_event(acc_ovf),
        .acc_input_event(acc_in), .chan_pin_in(pin_in), .chan_pin_out(pin_out),
        .chan_pin_oe_n(oe_n));
    timer_pin_partner u_pins (.pclk, .pin_out, .pin_oe_n(oe_n), .pin_level(pin_in));

    task automatic xfer(input logic w, input logic [5:0] i, input logic [7:0] d);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= {i, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata[7:0];
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] i, input logic [7:0] exp);
        xfer(1'b0, i, 8'h00);
        `CHK(rd, exp)
    endtask

    task automatic complete_run();
        if (n_mismatch == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge pclk);
        n_mismatch++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(6'h07, 8'h00);
        rd_chk(6'h08, 8'h00);
        xfer(1'b0, 6'h30, 8'h00);
        `CHK({err, rd}, 9'h100)
        foreach (cfg[k]) xfer(1'b1, cfg[k][13:8], cfg[k][7:0]);
        @(posedge pclk);
        `CHK(oe_n, 8'h38)
        xfer(1'b1, 6'h06, 8'h88);
        repeat (64) @(posedge pclk);
        `CHK(pin_out & 8'hCF, 8'hC3)
        rd_chk(6'h0E, 8'hCF);
        xfer(1'b1, 6'h06, 8'h80);
        rd_chk(6'h06, 8'h88);
        xfer(1'b1, 6'h10, 8'h00);
        rd_chk(6'h0E, 8'hCF);
        xfer(1'b1, 6'h0E, 8'h02);
        rd_chk(6'h0E, 8'hCD);
        xfer(1'b1, 6'h06, 8'h90);
        xfer(1'b1, 6'h10, 8'h00);
        rd_chk(6'h0E, 8'hCC);
        u_pins.drive(8'h30);
        repeat (6) @(posedge pclk);
        rd_chk(6'h0E, 8'hDC);
        u_pins.drive(8'h00);
        repeat (6) @(posedge pclk);
        rd_chk(6'h0E, 8'hFC);
        xfer(1'b0, 6'h19, 8'h00);
        rd_chk(6'h0E, 8'hEC);
        // ch4 on any edge, ch5 off
        xfer(1'b1, 6'h0A, 8'h03);
        xfer(1'b1, 6'h0E, 8'h20);
        u_pins.drive(8'h30);
        repeat (6) @(posedge pclk);
        u_pins.drive(8'h00);
        repeat (6) @(posedge pclk);
        rd_chk(6'h0E, 8'hDC);
        acc_ovf <= 1'b1;
        acc_in  <= 1'b1;
        @(posedge pclk);
        acc_ovf <= 1'b0;
        acc_in  <= 1'b0;
        rd_chk(6'h21, 8'h03);
        rd_chk(6'h23, 8'h5A);
        rd_chk(6'h21, 8'h00);
        // input event lands on the very edge of a write-one clear
        fork
            xfer(1'b1, 6'h21, 8'h03);
            begin
                repeat (2) @(posedge pclk);
                acc_in <= 1'b1;
                @(posedge pclk);
                acc_in <= 1'b0;
            end
        join
        rd_chk(6'h21, 8'h01);
        xfer(1'b1, 6'h06, 8'h80);
        // ch0 and ch7 handed to the accumulator; ch3 compare lands on the wrap cycle
        xfer(1'b1, 6'h09, 8'hA4);
        xfer(1'b1, 6'h08, 8'h20);
        xfer(1'b1, 6'h02, 8'h40);
        xfer(1'b1, 6'h17, 8'h00);
        xfer(1'b1, 6'h07, 8'h1A);
        @(posedge pclk);
        `CHK(oe_n, 8'hB1)
        // ch1 falls only when the counter wraps; ch3 clear loses to its toggle
        for (int n = 0; n < 70000 && pin_out[1] !== 1'b0; n++) @(posedge pclk);
        rd_chk(6'h0F, 8'h80);
        `CHK(pin_out & 8'h0F, 8'h09)
        xfer(1'b0, 6'h04, 8'h00);
        rd_chk(6'h0F, 8'h80);
        xfer(1'b1, 6'h06, 8'h90);
        xfer(1'b0, 6'h05, 8'h00);
        rd_chk(6'h0F, 8'h00);
        complete_run();
    end
endmodule // test_timer_channel_action_control
